// [far_ops_regs.vh]
`ifndef FAR_OPS_REGS_VH
`define FAR_OPS_REGS_VH

// operation codes
`define OP_W                      4
`define OP_FAR_MOVE_TO_ACC        4'h0
`define OP_FAR_MOVE_TO_MEM        4'h1
`define OP_FAR_OR_TO_ACC          4'h2
`define OP_FAR_OR_TO_MEM          4'h3
`define OP_FAR_ROTATE_LEFT        4'h4
`define OP_FAR_ROTATE_LEFT_ACC    4'h5
`define OP_FAR_ROTATE_LEFT_THRU   4'h6
`define OP_FAR_ROTATE_LEFT_THRU_A 4'h7
`define OP_FAR_ROTATE_RIGHT       4'h8
`define OP_FAR_ROTATE_RIGHT_ACC   4'h9
`define OP_FAR_ROTATE_RIGHT_THRU  4'hA

// status word layout
`define STATUS_W                  6
`define STATUS_C                  0
`define STATUS_AC                 1
`define STATUS_Z                  2
`define STATUS_OV                 3
`define STATUS_SC                 4
`define STATUS_CZ                 5

// widths and reset values
`define DATA_W                    8
`define ADDR_W                    8
`define MEM_DEPTH                 256
`define ACC_RESET                 8'h00
`define STATUS_RESET              6'h00
`define DATA_ZERO                 8'h00

`endif

// [byte_rotator.v]
`timescale 1ns/1ps
module byte_rotator (
	// operand
	input  wire [7:0] din,
	input  wire       cin,
	// mode
	input  wire       right,
	input  wire       thru,
	// result
	output reg  [7:0] dout,
	output reg        cout
);

	always @* begin
		if (right) begin
			dout = {(thru ? cin : din[0]), din[7:1]};
			cout = thru ? din[0] : cin;
		end else begin
			dout = {din[6:0], (thru ? cin : din[7])};
			cout = thru ? din[7] : cin;
		end
	end

endmodule // byte_rotator

// [data_ram.v]
`timescale 1ns/1ps
`include "far_ops_regs.vh"
module data_ram (
	// clock and reset
	input  wire                 clk,
	input  wire                 rst_n,
	// core port
	input  wire                 core_we,
	input  wire [`ADDR_W-1:0]   core_addr,
	input  wire [`DATA_W-1:0]   core_wdata,
	output reg  [`DATA_W-1:0]   core_rdata,
	// side port
	input  wire                 side_we,
	input  wire [`ADDR_W-1:0]   side_addr,
	input  wire [`DATA_W-1:0]   side_wdata,
	output reg  [`DATA_W-1:0]   side_rdata
);

	reg [`DATA_W-1:0] mem [0:`MEM_DEPTH-1];

	// writes, core port wins on a clash
	always @(posedge clk) begin
		if (core_we) begin
			mem[core_addr] <= core_wdata;
		end
		if (side_we && !(core_we && core_addr == side_addr)) begin
			mem[side_addr] <= side_wdata;
		end
	end

	// registered reads
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_rdata <= `DATA_ZERO;
			side_rdata <= `DATA_ZERO;
		end else begin
			core_rdata <= mem[core_addr];
			side_rdata <= mem[side_addr];
		end
	end

endmodule // data_ram

// [far_ops_core.v]
// What this block does
// - move memory byte to accumulator, flags kept
// - move accumulator to memory byte, flags kept
// - OR into accumulator, only zero flag
// - OR into memory, only zero flag
// - rotate memory left, bit7 to bit0
// - rotate left into accumulator, memory kept
// - rotate memory left through carry flag
// - rotate left through carry into accumulator
// - rotate memory right, bit0 to bit7
// - rotate right into accumulator, memory kept
// - rotate memory right through carry flag
`timescale 1ns/1ps
`include "far_ops_regs.vh"
module far_ops_core (
	// clock and reset
	input  wire                 REF_CLK,
	input  wire                 RSTN,
	// instruction request
	input  wire                 START,
	input  wire [`OP_W-1:0]     OPCODE,
	input  wire [`ADDR_W-1:0]   ADDR,
	// instruction status
	output reg                  BUSY,
	output reg                  DONE,
	output reg                  BAD_OP,
	// accumulator and status word
	input  wire                 ACC_LOAD,
	input  wire [`DATA_W-1:0]   ACC_LOAD_DATA,
	input  wire                 STATUS_LOAD,
	input  wire [`STATUS_W-1:0] STATUS_LOAD_DATA,
	output reg  [`DATA_W-1:0]   ACC,
	output reg  [`STATUS_W-1:0] STATUS,
	// side access to data memory
	input  wire                 MEM_WE,
	input  wire [`ADDR_W-1:0]   MEM_ADDR,
	input  wire [`DATA_W-1:0]   MEM_WDATA,
	output wire [`DATA_W-1:0]   MEM_RDATA
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	reg                  state;
	reg                  next_state;
	reg [`OP_W-1:0]      op;
	reg [`ADDR_W-1:0]    addr;

	reg [`DATA_W-1:0]    next_acc;
	reg [`STATUS_W-1:0]  next_status;
	reg                  mem_we;
	reg [`DATA_W-1:0]    mem_wdata;
	reg                  op_known;
	reg                  rot_right;
	reg                  rot_thru;
	reg                  to_acc;
	reg                  to_mem;
	reg                  from_acc;
	reg                  from_or;
	reg                  from_rot;
	reg                  sets_zero;
	reg                  sets_carry;
	reg [`DATA_W-1:0]    result;

	wire [`ADDR_W-1:0]   core_addr;
	wire [`DATA_W-1:0]   mem_q;
	wire [`DATA_W-1:0]   rot_out;
	wire                 rot_cout;
	wire [`DATA_W-1:0]   or_res;
	wire                 take;
	wire                 idle;
	wire                 in_exec;
	wire                 load_ok;
	wire                 side_we;

	////////////////////////////////////////////////////////////////////////
	// request capture

	assign take      = (state == ST_IDLE) && START;
	assign core_addr = (state == ST_IDLE) ? ADDR : addr;
	assign or_res    = ACC | mem_q;

	// write and load windows
	assign idle      = (state == ST_IDLE);
	assign in_exec   = (state == ST_EXEC);
	assign load_ok   = idle && !START;
	assign side_we   = MEM_WE && load_ok;

	// request latch
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			op   <= `OP_FAR_MOVE_TO_ACC;
			addr <= {`ADDR_W{1'b0}};
		end else if (take) begin
			op   <= OPCODE;
			addr <= ADDR;
		end
	end

	// next state
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (START) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// data memory and rotator

	data_ram u_ram (
		.clk        (REF_CLK),
		.rst_n      (RSTN),
		.core_we    (mem_we),
		.core_addr  (core_addr),
		.core_wdata (mem_wdata),
		.core_rdata (mem_q),
		.side_we    (side_we),
		.side_addr  (MEM_ADDR),
		.side_wdata (MEM_WDATA),
		.side_rdata (MEM_RDATA)
	);

	byte_rotator u_rot (
		.din   (mem_q),
		.cin   (STATUS[`STATUS_C]),
		.right (rot_right),
		.thru  (rot_thru),
		.dout  (rot_out),
		.cout  (rot_cout)
	);

	////////////////////////////////////////////////////////////////////////
	// decode

	always @* begin
		op_known   = 1'b1;
		to_acc     = 1'b0;
		to_mem     = 1'b0;
		from_acc   = 1'b0;
		from_or    = 1'b0;
		from_rot   = 1'b0;
		sets_zero  = 1'b0;
		sets_carry = 1'b0;
		rot_right  = 1'b0;
		rot_thru   = 1'b0;
		case (op)
			`OP_FAR_MOVE_TO_ACC: begin
				to_acc = 1'b1;
			end
			`OP_FAR_MOVE_TO_MEM: begin
				to_mem   = 1'b1;
				from_acc = 1'b1;
			end
			`OP_FAR_OR_TO_ACC: begin
				to_acc    = 1'b1;
				from_or   = 1'b1;
				sets_zero = 1'b1;
			end
			`OP_FAR_OR_TO_MEM: begin
				to_mem    = 1'b1;
				from_or   = 1'b1;
				sets_zero = 1'b1;
			end
			`OP_FAR_ROTATE_LEFT: begin
				to_mem   = 1'b1;
				from_rot = 1'b1;
			end
			`OP_FAR_ROTATE_LEFT_ACC: begin
				to_acc   = 1'b1;
				from_rot = 1'b1;
			end
			`OP_FAR_ROTATE_LEFT_THRU: begin
				to_mem     = 1'b1;
				from_rot   = 1'b1;
				rot_thru   = 1'b1;
				sets_carry = 1'b1;
			end
			`OP_FAR_ROTATE_LEFT_THRU_A: begin
				to_acc     = 1'b1;
				from_rot   = 1'b1;
				rot_thru   = 1'b1;
				sets_carry = 1'b1;
			end
			`OP_FAR_ROTATE_RIGHT: begin
				to_mem    = 1'b1;
				from_rot  = 1'b1;
				rot_right = 1'b1;
			end
			`OP_FAR_ROTATE_RIGHT_ACC: begin
				to_acc    = 1'b1;
				from_rot  = 1'b1;
				rot_right = 1'b1;
			end
			`OP_FAR_ROTATE_RIGHT_THRU: begin
				to_mem     = 1'b1;
				from_rot   = 1'b1;
				rot_right  = 1'b1;
				rot_thru   = 1'b1;
				sets_carry = 1'b1;
			end
			default: begin
				op_known = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// result and write back

	// result mux
	always @* begin
		if (from_or) begin
			result = or_res;
		end else if (from_rot) begin
			result = rot_out;
		end else if (from_acc) begin
			result = ACC;
		end else begin
			result = mem_q;
		end
	end

	// write back, only in the execute cycle
	always @* begin
		next_acc    = ACC;
		next_status = STATUS;
		mem_we      = 1'b0;
		mem_wdata   = result;
		if (in_exec) begin
			if (to_acc) begin
				next_acc = result;
			end
			if (to_mem) begin
				mem_we = 1'b1;
			end
			if (sets_zero) begin
				next_status[`STATUS_Z] = (result == `DATA_ZERO);
			end
			if (sets_carry) begin
				next_status[`STATUS_C] = rot_cout;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// architectural state and outputs

	// state register
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// handshake flags
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			BUSY   <= 1'b0;
			DONE   <= 1'b0;
			BAD_OP <= 1'b0;
		end else begin
			BUSY   <= (next_state == ST_EXEC);
			DONE   <= in_exec;
			BAD_OP <= in_exec && !op_known;
		end
	end

	// accumulator
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ACC <= `ACC_RESET;
		end else if (in_exec) begin
			ACC <= next_acc;
		end else if (ACC_LOAD && load_ok) begin
			ACC <= ACC_LOAD_DATA;
		end
	end

	// status word
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			STATUS <= `STATUS_RESET;
		end else if (in_exec) begin
			STATUS <= next_status;
		end else if (STATUS_LOAD && load_ok) begin
			STATUS <= STATUS_LOAD_DATA;
		end
	end

endmodule // far_ops_core

// [far_ops_checker_assertions.sv]
`timescale 1ns/1ps
module far_ops_checker (
	// clock and reset
	input wire       REF_CLK,
	input wire       RSTN,
	// instruction
	input wire       START,
	input wire [3:0] OPCODE,
	input wire       BUSY,
	input wire       DONE,
	input wire       BAD_OP,
	// state
	input wire [7:0] ACC,
	input wire [5:0] STATUS
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RSTN);
	wire tk = START && !BUSY;
	reg  c_in = 1'b0;
	always @(posedge REF_CLK) if (tk) c_in <= STATUS[0];
	a_take_then_done: assert property (tk |=> BUSY ##1 (DONE && !BUSY))
		else $error("done timing");
	a_move_flags_kept: assert property (tk && OPCODE <= 4'h1 |-> ##2 STATUS == $past(STATUS, 2))
		else $error("move flags");
	a_or_acc_zero: assert property (tk && OPCODE == 4'h2 |-> ##2 STATUS[2] == (ACC == 8'h00))
		else $error("or zero flag");
	a_or_mem_acc: assert property (tk && OPCODE == 4'h3 |-> ##2 ACC == $past(ACC, 2))
		else $error("or mem acc");
	a_plain_rot_kept: assert property (tk && OPCODE[1:0] == 2'h0 && OPCODE[3:2] != 2'h0 |-> ##2 $stable(STATUS)
		[*1] ##0 ACC == $past(ACC, 2))
		else $error("plain rotate");
	a_rot_acc_flags: assert property (tk && (OPCODE == 4'h5 || OPCODE == 4'h9) |-> ##2 STATUS == $past(STATUS, 2))
		else $error("rotate acc flags");
	a_carry_only: assert property (tk && OPCODE >= 4'h6 && OPCODE != 4'h9 && OPCODE <= 4'hA && OPCODE != 4'h8 |-> ##2
		(STATUS & 6'h3E) == ($past(STATUS, 2) & 6'h3E))
		else $error("carry rotate flags");
	a_carry_into_acc: assert property (tk && OPCODE == 4'h7 |-> ##2 ACC[0] == c_in)
		else $error("carry into acc");
	a_bad_no_change: assert property (tk && OPCODE > 4'hA |-> ##2 BAD_OP && STATUS == $past(STATUS, 2))
		else $error("bad op");
	c_carry_acc: cover property (tk && OPCODE == 4'h7);
	c_bad_op: cover property (DONE && BAD_OP);
	c_or_zero: cover property (tk && OPCODE == 4'h2 ##2 STATUS[2]);
endmodule // far_ops_checker
bind far_ops_core far_ops_checker chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .START(START), .OPCODE(OPCODE),
	.BUSY(BUSY), .DONE(DONE), .BAD_OP(BAD_OP), .ACC(ACC), .STATUS(STATUS));

// [tb_extended_move_or_rotate_ops.sv]
`timescale 1ns/1ps
module tb_extended_move_or_rotate_ops;
	reg         REF_CLK = 1'b0, RSTN = 1'b0, START = 1'b0, ACC_LOAD = 1'b0, STATUS_LOAD = 1'b0, MEM_WE = 1'b0;
	reg  [3:0]  OPCODE = 4'h0;
	reg  [7:0]  ADDR = 8'h00, ACC_LOAD_DATA = 8'h00, MEM_ADDR = 8'h00, MEM_WDATA = 8'h00;
	reg  [5:0]  STATUS_LOAD_DATA = 6'h00;
	wire        BUSY, DONE, BAD_OP;
	wire [7:0]  ACC, MEM_RDATA;
	wire [5:0]  STATUS;
	reg  [7:0]  mem [0:255];
	reg  [7:0]  acc, d, v;
	reg  [5:0]  st;
	reg  [31:0] rnd;
	integer     failures = 0, checks_done = 0, cycles = 0, i;
	far_ops_core dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .START(START), .OPCODE(OPCODE), .ADDR(ADDR),
		.BUSY(BUSY), .DONE(DONE), .BAD_OP(BAD_OP), .ACC_LOAD(ACC_LOAD), .ACC_LOAD_DATA(ACC_LOAD_DATA),
		.STATUS_LOAD(STATUS_LOAD), .STATUS_LOAD_DATA(STATUS_LOAD_DATA), .ACC(ACC), .STATUS(STATUS),
		.MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));
	always #2.5 REF_CLK = ~REF_CLK;
	////////////////////////////////
	function [8:0] rot(input [3:0] op, input [7:0] x, input c);
		case (op)
			4'h4, 4'h5: rot = {c, x[6:0], x[7]};
			4'h6, 4'h7: rot = {x[7], x[6:0], c};
			4'h8, 4'h9: rot = {c, x[0], x[7:1]};
			default:    rot = {x[0], c, x[7:1]};
		endcase
	endfunction
	task chk(input string n, input [7:0] e, input [7:0] s);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("BAD %s exp %h got %h", n, e, s);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d failures %0d", checks_done, failures);
			if (failures == 0 && checks_done > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	// set memory byte, acc and flags together
	task put(input [7:0] a, input [5:0] s);
		begin
			@(posedge REF_CLK);
			{MEM_WE, MEM_ADDR, MEM_WDATA, ACC_LOAD, ACC_LOAD_DATA} <= {1'b1, a, d, 1'b1, v};
			{STATUS_LOAD, STATUS_LOAD_DATA} <= {1'b1, s};
			@(posedge REF_CLK);
			{MEM_WE, ACC_LOAD, STATUS_LOAD} <= 3'h0;
			mem[a] = d;
			acc = v;
			st = s;
		end
	endtask
	task exec(input [3:0] op, input [7:0] a);
		reg [8:0] r;
		reg [7:0] m;
		begin
			m = mem[a];
			r = rot(op, m, st[0]);
			@(posedge REF_CLK);
			{START, OPCODE, ADDR, MEM_ADDR} <= {1'b1, op, a, a};
			@(posedge REF_CLK);
			START <= 1'b0;
			#1;
			chk("busy", 8'h01, {7'h00, BUSY});
			@(posedge REF_CLK);
			#1;
			case (op)
				4'h0: acc = m;
				4'h1: mem[a] = acc;
				4'h2: acc = acc | m;
				4'h3: mem[a] = acc | m;
				4'h4, 4'h6, 4'h8, 4'hA: mem[a] = r[7:0];
				4'h5, 4'h7, 4'h9: acc = r[7:0];
				default: ;
			endcase
			if (op == 4'h2 || op == 4'h3) st[2] = (acc | m) == 8'h00;
			if (op == 4'h6 || op == 4'h7 || op == 4'hA) st[0] = r[8];
			chk("done", {6'h00, 1'b1, op > 4'hA}, {6'h00, DONE, BAD_OP});
			chk("acc", acc, ACC);
			chk("flags", {2'h0, st}, {2'h0, STATUS});
			@(posedge REF_CLK);
			#1;
			chk("mem", mem[a], MEM_RDATA);
		end
	endtask
	////////////////////////////////
	always @(posedge REF_CLK) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			failures = failures + 1;
			give_verdict;
		end
	end
	initial begin
		rnd = $urandom(34892);
		repeat (4) @(posedge REF_CLK);
		RSTN <= 1'b1;
		// zero operands, then 81 pattern, then random
		for (i = 0; i < 96; i = i + 1) begin
			rnd = $urandom;
			d = (i < 16) ? 8'h00 : (i < 32) ? 8'h81 : rnd[31:24];
			v = (i < 16) ? 8'h00 : rnd[15:8];
			put(rnd[7:0], rnd[21:16]);
			exec(i[3:0], rnd[7:0]);
			$display("test %0d ended", i);
		end
		give_verdict;
	end
endmodule // tb_extended_move_or_rotate_ops
